/* inc/modem_port_consts.svh */
`ifndef MODEM_PORT_CONSTS_SVH
`define MODEM_PORT_CONSTS_SVH

// Host port select codes.
`define HPS_PARALLEL 2'h0
`define HPS_SERIAL 2'h1

// Converter path select codes.
`define CPS_NORMAL 3'h7
`define CPS_BYPASS_ADC 3'h6
`define CPS_BYPASS_DAC 3'h5

// Register file geometry and reset value.
`define REG_DEPTH 256
`define REG_RESET 8'h00

// Host register map: order, status, read data.
`define HOST_CMD_OFS 4'h0
`define HOST_STAT_OFS 4'h4
`define HOST_RDATA_OFS 4'h8

// Host command fields.
`define CMD_ADDR_LSB 0
`define CMD_DATA_LSB 8
`define CMD_READ_BIT 16

// Strobe low time on the parallel bus, in core cycles.
`define STROBE_NS 60
`define CLK_NS 20
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)

// FEC test clock is eight times the symbol rate.
`define FEC_MULT 8

`endif

/* inc/modem_port_pkg.sv */
`default_nettype none
package modem_port_pkg;
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_SETUP = 4'b0010,
    HS_STROBE = 4'b0100,
    HS_DONE = 4'b1000
  } host_state_t;

  typedef logic [7:0] reg_byte_t;
endpackage : modem_port_pkg
`default_nettype wire

/* inc/modem_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface modem_port_if;
  logic [1:0] hostPortSelect;
  logic chipSelect_n;
  logic readWrite_n;
  logic transferStrobe_n;
  logic [7:0] address;
  logic [7:0] hostDataOut;
  logic hostDataOe;
  logic [7:0] devDataOut;
  logic devDataOe;
  logic [7:0] busData;

  // The shared data bus level is resolved here from the two enables.
  assign busData = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : 8'hff);

  modport device (
    input hostPortSelect, chipSelect_n, readWrite_n, transferStrobe_n, address, busData,
    output devDataOut, devDataOe
  );
  modport host (
    output hostPortSelect, chipSelect_n, readWrite_n, transferStrobe_n, address, hostDataOut, hostDataOe,
    input busData
  );
endinterface : modem_port_if
`default_nettype wire

/* rtl/modem_port_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modem_port_consts.svh"

// Behaviour
// - port select 00 parallel, 01 serial
// - host never drives select 10 or 11
// - strobes ignored unless chip select low
// - read_write_n low writes, high reads
// - act only while strobe is low
// - host presents eight-bit address
// - eight-bit shared data bus both ways
// - converter path select 111 normal, 110/101 bypass
// - multiplier runs only when enabled
// - multiplied and gated clock outputs only when gate asserted
// - FEC test clock eight times symbol
module modem_port_device #(
  parameter int DEPTH = `REG_DEPTH,
  parameter int FEC_MULT = `FEC_MULT
) (
  input wire logic core_clk,
  input wire logic rst,
  modem_port_if.device port,
  input wire logic [2:0] converterPathSelect,
  input wire logic [9:0] converterTestIn,
  output logic [9:0] converterTestOut,
  output logic converterTestOe,
  input wire logic [9:0] adcSample,
  output logic [9:0] adcSampleUsed,
  input wire logic [9:0] dacSample,
  output logic [9:0] dacSampleUsed,
  input wire logic rxMultiplierEnable,
  input wire logic clockOutputGate,
  output logic rxMultipliedClock,
  output logic gatedClockOut,
  input wire logic symbolTick,
  output logic fecTestClock,
  output logic [9:0] testMuxData,
  output logic testMuxClock
);
  // The index is the full eight-bit address and the tick counter has four bits.
  if (DEPTH != 256 || FEC_MULT < 1 || FEC_MULT > 8)
  begin : g_bad_params
    $error("modem_port_device: unsupported parameters.");
  end

  // Register file in flip-flops, indexed straight by the eight-bit address.
  modem_port_pkg::reg_byte_t regs_ff [DEPTH];
  // Strobe seen low at the last edge; its return to high ends a transfer.
  logic strobeDly_ff;
  logic wasWrite_ff;
  logic [7:0] wrAddr_ff;
  logic [7:0] wrData_ff;
  logic mulDiv_ff;
  logic [3:0] fecCnt_ff;
  logic fecClk_ff;
  logic tstClk_ff;
  logic [9:0] tstData_ff;
  logic parallelSel;
  logic accessOn;
  logic commitWrite;

  // Both clock outputs share one gate so they cannot drift apart.
  function automatic logic gateClock(input logic enable, input logic clk);
    return enable && clk;
  endfunction : gateClock

  assign parallelSel = port.hostPortSelect == `HPS_PARALLEL;
  // Serial select leaves the parallel pins dead; its shifter lives elsewhere.
  assign accessOn = parallelSel && !port.chipSelect_n && !port.transferStrobe_n;

  // Capture the cycle while the strobe is low, commit on its release.
  // Address and direction hold for the whole frame, so the last strobed copy is the one used.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      strobeDly_ff <= 1'b0;
      wasWrite_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      wrData_ff <= 8'h00;
    end
    else
    begin
      strobeDly_ff <= accessOn;
      if (accessOn)
      begin
        wasWrite_ff <= !port.readWrite_n;
        wrAddr_ff <= port.address;
        wrData_ff <= port.busData;
      end
    end
  end

  // The write lands when the strobe rises with chip select still low, as a bus
  // latch would; a frame cut short by chip select rising first is dropped.
  assign commitWrite = strobeDly_ff && !accessOn && wasWrite_ff && !port.chipSelect_n;

  // Every location reads as zero after reset so software sees a known map.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        regs_ff[i] <= `REG_RESET;
      end
    end
    else if (commitWrite)
    begin
      regs_ff[wrAddr_ff] <= wrData_ff;
    end
  end

  // Read data is combinational from the array so it is valid while the strobe is low.
  // The host owns the bus on writes, so the device drives only during a read strobe.
  assign port.devDataOe = accessOn && port.readWrite_n;
  assign port.devDataOut = regs_ff[port.address];

  // Converter path steering.
  // ADC bypass feeds test-port samples into the receive path; DAC bypass sends transmit samples out.
  always_comb
  begin
    converterTestOut = 10'h000;
    converterTestOe = 1'b0;
    adcSampleUsed = adcSample;
    dacSampleUsed = dacSample;
    case (converterPathSelect)
      `CPS_NORMAL: ;
      `CPS_BYPASS_ADC: adcSampleUsed = converterTestIn;
      `CPS_BYPASS_DAC:
      begin
        converterTestOut = dacSample;
        converterTestOe = 1'b1;
      end
      default: ;
    endcase
  end

  // Multiplied clock is modelled as a half-rate toggle of the core clock.
  // Holding the divider low while disabled gives a defined phase when it restarts.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mulDiv_ff <= 1'b0;
    end
    else if (rxMultiplierEnable)
    begin
      mulDiv_ff <= !mulDiv_ff;
    end
    else
    begin
      mulDiv_ff <= 1'b0;
    end
  end

  assign rxMultipliedClock = gateClock(clockOutputGate, mulDiv_ff);
  assign gatedClockOut = gateClock(clockOutputGate, mulDiv_ff);

  // Eight clock periods per symbol tick give a clock at eight times the symbol rate
  // provided ticks are at least 2*FEC_MULT cycles apart.
  // A tick arriving mid-burst restarts the burst and cuts the previous one short.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fecCnt_ff <= 4'h0;
      fecClk_ff <= 1'b0;
    end
    else if (symbolTick)
    begin
      fecCnt_ff <= 4'(2 * FEC_MULT - 1);
      fecClk_ff <= 1'b1;
    end
    else if (fecCnt_ff != 4'h0)
    begin
      fecCnt_ff <= fecCnt_ff - 4'h1;
      fecClk_ff <= !fecClk_ff;
    end
  end
  assign fecTestClock = fecClk_ff;

  // Observed samples change on the falling edge of their clock.
  // The observed sample follows the receive path, so ADC bypass shows up here too.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tstClk_ff <= 1'b0;
      tstData_ff <= 10'h000;
    end
    else
    begin
      tstClk_ff <= !tstClk_ff;
      if (tstClk_ff)
      begin
        tstData_ff <= adcSampleUsed;
      end
    end
  end
  // Data change as the clock falls, so a receiver samples them on the rising edge.
  assign testMuxClock = tstClk_ff;
  assign testMuxData = tstData_ff;
endmodule : modem_port_device
`default_nettype wire

/* rtl/modem_port_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modem_port_consts.svh"

module modem_port_host (
  input wire logic core_clk,
  input wire logic rst,
  modem_port_if.host port,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  modem_port_pkg::host_state_t state_ff;
  logic [7:0] addr_ff;
  logic [7:0] wdata_ff;
  logic isRead_ff;
  logic [7:0] rdata_ff;
  logic [3:0] cnt_ff;
  logic idle;

  assign idle = state_ff == modem_port_pkg::HS_IDLE;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= modem_port_pkg::HS_IDLE;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      isRead_ff <= 1'b0;
      rdata_ff <= 8'h00;
      cnt_ff <= 4'h0;
    end
    else
    begin
      case (state_ff)
        modem_port_pkg::HS_IDLE:
          if (avs_write && avs_address == `HOST_CMD_OFS)
          begin
            addr_ff <= avs_writedata[`CMD_ADDR_LSB +: 8];
            wdata_ff <= avs_writedata[`CMD_DATA_LSB +: 8];
            isRead_ff <= avs_writedata[`CMD_READ_BIT];
            state_ff <= modem_port_pkg::HS_SETUP;
          end
        modem_port_pkg::HS_SETUP:
        begin
          cnt_ff <= 4'(`STROBE_CYC);
          state_ff <= modem_port_pkg::HS_STROBE;
        end
        modem_port_pkg::HS_STROBE:
          if (cnt_ff == 4'h1)
          begin
            if (isRead_ff)
            begin
              rdata_ff <= port.busData;
            end
            state_ff <= modem_port_pkg::HS_DONE;
          end
          else
          begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        modem_port_pkg::HS_DONE: state_ff <= modem_port_pkg::HS_IDLE;
        default: state_ff <= modem_port_pkg::HS_IDLE;
      endcase
    end
  end

  // Only the parallel port is served; reserved codes are never driven.
  assign port.hostPortSelect = `HPS_PARALLEL;
  assign port.chipSelect_n = idle;
  assign port.readWrite_n = isRead_ff;
  assign port.transferStrobe_n = state_ff != modem_port_pkg::HS_STROBE;
  assign port.address = addr_ff;
  assign port.hostDataOut = wdata_ff;
  assign port.hostDataOe = !idle && !isRead_ff;

  // Command writes wait while a cycle runs; everything else answers at once.
  assign avs_waitrequest = avs_write && avs_address == `HOST_CMD_OFS && !idle;

  always_comb
  begin
    avs_readdata = 32'h0;
    if (avs_read)
    begin
      case (avs_address)
        `HOST_STAT_OFS: avs_readdata = {31'h0, !idle};
        `HOST_RDATA_OFS: avs_readdata = {24'h0, rdata_ff};
        default: avs_readdata = 32'h0;
      endcase
    end
  end
endmodule : modem_port_host
`default_nettype wire

/* verification/modem_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module modem_port_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] hostPortSelect,
  input wire logic chipSelect_n,
  input wire logic readWrite_n,
  input wire logic transferStrobe_n,
  input wire logic [7:0] address,
  input wire logic hostDataOe,
  input wire logic devDataOe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_sel;
    hostPortSelect == 2'h0;
  endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_setup;
    $fell(chipSelect_n) |-> transferStrobe_n ##1 !transferStrobe_n;
  endproperty
  a_setup: assert property (p_setup) else $error("setup");
  property p_frame;
    $fell(chipSelect_n) |-> !chipSelect_n [*5] ##1 chipSelect_n;
  endproperty
  a_frame: assert property (p_frame) else $error("frame");
  property p_strobe;
    $fell(transferStrobe_n) |-> !transferStrobe_n [*3] ##1 transferStrobe_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe");
  property p_release;
    devDataOe |-> hostPortSelect == 2'h0 && !chipSelect_n && !transferStrobe_n && readWrite_n;
  endproperty
  a_release: assert property (p_release) else $error("release");
  property p_read;
    !chipSelect_n && !transferStrobe_n && readWrite_n |-> devDataOe;
  endproperty
  a_read: assert property (p_read) else $error("read");
  property p_write;
    !transferStrobe_n && !readWrite_n |-> hostDataOe && !devDataOe;
  endproperty
  a_write: assert property (p_write) else $error("write");
  property p_hold;
    !chipSelect_n && !$past(chipSelect_n) |-> $stable(address) && $stable(readWrite_n);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  cover property ($fell(transferStrobe_n) && readWrite_n);
  cover property ($fell(transferStrobe_n) && !readWrite_n);
  cover property ($rose(chipSelect_n));
endmodule : modem_port_asserts
`default_nettype wire

/* verification/modem_host_port_and_mode_pins_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modem_port_consts.svh"
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin badCount++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module modem_host_port_and_mode_pins_bench;
  logic core_clk;
  logic rst = 1'b1;
  logic [3:0] avAddr = 4'h0;
  logic avRead = 1'b0;
  logic avWrite = 1'b0;
  logic [31:0] avWdata = 32'h0;
  logic [31:0] avRdata;
  logic avWait;
  logic [2:0] pathSel = `CPS_NORMAL;
  logic [9:0] testIn = 10'h2c3;
  logic [9:0] adcIn = 10'h15a;
  logic [9:0] dacIn = 10'h0f1;
  logic multEn = 1'b0;
  logic gate = 1'b0;
  logic tick = 1'b0;
  logic [9:0] testOut, adcUsed, dacUsed, muxData;
  logic testOe, multClk, gatedClk, fecClk, muxClk;
  int badCount = 0;
  int nChecks = 0;
  logic [31:0] w;
  modem_port_pkg::reg_byte_t rd;
  int fecRises = 0;
  logic prevClk;
  logic [7:0] av [4] = '{8'h00, 8'hff, 8'h5a, 8'ha5};
  modem_port_if mif();
  modem_port_device u_modem_port_device (.core_clk(core_clk), .rst(rst), .port(mif),
    .converterPathSelect(pathSel), .converterTestIn(testIn), .converterTestOut(testOut),
    .converterTestOe(testOe), .adcSample(adcIn), .adcSampleUsed(adcUsed), .dacSample(dacIn),
    .dacSampleUsed(dacUsed), .rxMultiplierEnable(multEn), .clockOutputGate(gate),
    .rxMultipliedClock(multClk), .gatedClockOut(gatedClk), .symbolTick(tick),
    .fecTestClock(fecClk), .testMuxData(muxData), .testMuxClock(muxClk));
  modem_port_host u_modem_port_host (.core_clk(core_clk), .rst(rst), .port(mif), .avs_address(avAddr),
    .avs_read(avRead), .avs_write(avWrite), .avs_writedata(avWdata), .avs_readdata(avRdata),
    .avs_waitrequest(avWait));
  modem_port_asserts u_modem_port_asserts (.core_clk(core_clk), .rst(rst),
    .hostPortSelect(mif.hostPortSelect), .chipSelect_n(mif.chipSelect_n), .readWrite_n(mif.readWrite_n),
    .transferStrobe_n(mif.transferStrobe_n), .address(mif.address), .hostDataOe(mif.hostDataOe),
    .devDataOe(mif.devDataOe));
  task automatic avCycle(input logic isRd, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avAddr <= a;
    avWdata <= d;
    avRead <= isRd;
    avWrite <= !isRd;
    do @(posedge core_clk); while (avWait !== 1'b0);
    w = avRdata;
    avRead <= 1'b0;
    avWrite <= 1'b0;
  endtask : avCycle
  task automatic regOp(input logic isRd, input logic [7:0] a, input logic [7:0] d);
    avCycle(1'b0, `HOST_CMD_OFS, {15'h0, isRd, d, a});
    w = 32'h1;
    for (int i = 0; i < 20 && w[0] !== 1'b0; i++) avCycle(1'b1, `HOST_STAT_OFS, 32'h0);
    `CHK(w[0], 1'b0)
    if (isRd) avCycle(1'b1, `HOST_RDATA_OFS, 32'h0);
    rd = w[7:0];
  endtask : regOp
  task giveVerdict();
    $display("mismatches %0d checks %0d", badCount, nChecks);
    if (badCount == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : giveVerdict
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    #200000;
    badCount++;
    giveVerdict();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    foreach (av[i]) regOp(1'b0, av[i], av[i] ^ 8'hc3);
    foreach (av[i])
    begin
      regOp(1'b1, av[i], 8'h00);
      `CHK(rd, av[i] ^ 8'hc3)
    end
    // A read carries a data field that must never reach the register.
    regOp(1'b1, 8'h01, 8'hee);
    regOp(1'b1, 8'h01, 8'h00);
    `CHK(rd, 8'h00)
    // The second order stalls on waitrequest until the first one is done.
    avCycle(1'b0, `HOST_CMD_OFS, 32'h00007710);
    avCycle(1'b0, `HOST_CMD_OFS, 32'h00008811);
    regOp(1'b1, 8'h10, 8'h00);
    `CHK(rd, 8'h77)
    regOp(1'b1, 8'h11, 8'h00);
    `CHK(rd, 8'h88)
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    regOp(1'b1, 8'hff, 8'h00);
    `CHK(rd, 8'h00)
    pathSel <= `CPS_BYPASS_ADC;
    @(negedge core_clk);
    `CHK(adcUsed, testIn)
    `CHK(testOe, 1'b0)
    @(posedge core_clk) pathSel <= `CPS_BYPASS_DAC;
    @(negedge core_clk);
    `CHK(testOe, 1'b1)
    `CHK(testOut, dacIn)
    @(posedge core_clk) pathSel <= `CPS_NORMAL;
    @(negedge core_clk);
    `CHK(adcUsed, adcIn)
    `CHK(testOe, 1'b0)
    `CHK(dacUsed, dacIn)
    @(posedge core_clk) multEn <= 1'b1;
    repeat (4)
    begin
      @(negedge core_clk);
      `CHK(gatedClk, 1'b0)
      `CHK(multClk, 1'b0)
    end
    @(posedge core_clk);
    multEn <= 1'b0;
    gate <= 1'b1;
    repeat (4)
    begin
      @(negedge core_clk);
      `CHK(multClk, 1'b0)
    end
    @(posedge core_clk) multEn <= 1'b1;
    repeat (2) @(negedge core_clk);
    w[0] = multClk;
    @(negedge core_clk);
    `CHK(multClk, ~w[0])
    `CHK(gatedClk, multClk)
    // One symbol tick must give FEC_MULT clock periods, then the clock rests low.
    @(posedge core_clk) tick <= 1'b1;
    @(posedge core_clk) tick <= 1'b0;
    prevClk = 1'b0;
    repeat (20)
    begin
      @(negedge core_clk);
      if (fecClk && !prevClk) fecRises++;
      prevClk = fecClk;
    end
    `CHK(fecRises, `FEC_MULT)
    `CHK(fecClk, 1'b0)
    // Test mux clock toggles every cycle and its data follow the receive sample.
    @(posedge core_clk) adcIn <= 10'h2a5;
    @(negedge core_clk);
    prevClk = muxClk;
    repeat (4)
    begin
      @(negedge core_clk);
      `CHK(muxClk, ~prevClk)
      prevClk = muxClk;
      if (!muxClk) `CHK(muxData, 10'h2a5)
    end
    giveVerdict();
  end
endmodule : modem_host_port_and_mode_pins_bench
`default_nettype wire
